// ==== hw/fwa_defines.svh ====
// register offsets, field positions, reset values and code constants
// assumes inclusion by the alert block and the test bench only
`ifndef FWA_DEFINES_SVH
`define FWA_DEFINES_SVH

// register byte offsets
`define OFS_CONTROL 8'h00
`define OFS_STATUS 8'h04
`define OFS_ALERT1 8'h08
`define OFS_ALERT2 8'h0C
`define OFS_VIN_LIM 8'h10
`define OFS_VOUT_LIM 8'h14
`define OFS_IOUT_LIM 8'h18
`define OFS_IOUT_CODE 8'h1C
`define OFS_V_CODE 8'h20
`define OFS_LIVE 8'h24

// control, alert polarity and second current limit direction fields
`define CTL_CLEAR_BIT 0
`define CTL_RANGE_BIT 1
`define CTL_ON_BIT 7
`define ALERT_INV_BIT 16
`define W2_UNDER_BIT 31

// status bit positions
`define ST_UV_FAULT 0
`define ST_OV_FAULT 1
`define ST_OC_TIMEOUT 2
`define ST_COMM_ERR 3
`define ST_REG_ACTIVE 4
`define ST_IOUT_OC 5
`define ST_IOUT_W2 6
`define ST_VIN_UV 7
`define ST_VIN_OV 8
`define ST_VOUT_UV 9
`define ST_VOUT_OV 10
`define ST_FET_BAD 11

// reset values
`define RST_OV_LIMIT 12'hFFF
`define RST_UV_LIMIT 12'h000
`define RST_W2_LIMIT 12'h000
`define RST_ALERT1_EN 12'h000
`define RST_ALERT2_EN 12'h800

// code scaling: current zero at mid code, steps in stated units
`define CUR_ZERO_CODE 12'h800
`define CUR_STEP_NV 12400
`define V_STEP_LOW_UV 1488
`define V_STEP_HIGH_UV 5208

// alert response exchange and bus response codes
`define ARA_ADDR 7'h0C
`define ARA_READ_BYTE 8'h19
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== hw/fwa_pkg.sv ====
// types of the fault, warning and alert block
// assumes fwa_defines.svh for the numbers; types only here
package fwa_pkg;

  typedef enum logic [2:0] {
    ARA_IDLE,
    ARA_ADDR,
    ARA_ACK,
    ARA_SEND,
    ARA_WAIT
  } ara_t;

  typedef struct packed {
    logic [4:0] pin_s1;
    logic [4:0] pin_s2;
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic [11:0] status;
    logic [11:0] en1;
    logic [11:0] en2;
    logic inv1;
    logic inv2;
    logic [1:0] alert;
    logic op_on;
    logic tripped;
    logic v_range;
    logic w2_under;
    logic [11:0] vin_ov;
    logic [11:0] vin_uv;
    logic [11:0] vout_ov;
    logic [11:0] vout_uv;
    logic [11:0] iout_oc;
    logic [11:0] iout_w2;
    logic [11:0] iout_code;
    logic [11:0] vin_code;
    logic [11:0] vout_code;
    ara_t ara;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic sda_oe;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

endpackage

// ==== hw/fault_warning_alert_logic.sv ====
// fault/warning status latching, alert pins and alert response answer
// assumes: AXI4-Lite master on MCLK, ADC codes on MCLK with a strobe,
// fault comparators, bus clock and data arriving from outside MCLK
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`include "fwa_defines.svh"

// Behaviour
// R01 - current codes are 12-bit offset binary, 2048 zero, 12.4 uV steps
// R02 - voltage is (code plus half) times 1.488 mV or 5.208 mV step
// R03 - reading back codes returns the raw converter output unchanged
// R04 - undervoltage, overvoltage, overcurrent timeout are faults; all turn output off
// R05 - fault detection always runs and no setting can disable it
// R06 - status bits read 1 when active and latch until cleared
// R07 - clear or off-then-on clears a bit only if condition is gone
// R08 - nine warnings never change the output state
// R09 - alert pins released at power-up, first alert has nothing enabled
// R10 - second alert has transistor health-bad enabled from power-up
// R11 - enabled event drives alert active, low unless inverted
// R12 - alert asserts only on an enabled bit going 0 to 1
// R13 - alerts assert independently but always deassert together
// R14 - clear deasserts alerts; persistent bits need a new event
// R15 - next out-of-limit sample after a clear raises a new alert
// R16 - host reads address 0x0C; alerting device returns own 7-bit address
// R17 - lowest address wins arbitration; only the winner releases alert
// R18 - winner releases alert during the acknowledge bit after the address
// R19 - host repeats alert response reads while the alert line stays low
// R20 - single-device host may read status then clear faults
// R21 - warnings need strictly above or strictly below the threshold
// R22 - alert response leaves latched status bits unchanged
module fault_warning_alert_logic #(
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // axi4-lite write address and data
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // analog fault and status pins, asynchronous
  input wire logic UV_FAULT_IN,
  input wire logic OV_FAULT_IN,
  input wire logic OC_TIMEOUT_IN,
  input wire logic REGULATION_ACTIVE_IN,
  input wire logic FET_HEALTH_BAD_IN,
  // bus error event from the command interface, on MCLK
  input wire logic COMM_ERROR_EVENT,
  // converter samples, on MCLK
  input wire logic ADC_VALID,
  input wire logic [11:0] ADC_IOUT_CODE,
  input wire logic [11:0] ADC_V_CODE,
  input wire logic ADC_V_IS_VOUT,
  // hot-swap output enable
  output logic HOT_SWAP_ON,
  // open-drain alert pins
  output logic FIRST_ALERT_O,
  output logic FIRST_ALERT_OE,
  output logic SECOND_ALERT_O,
  output logic SECOND_ALERT_OE,
  // smbus pins
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_O,
  output logic SDA_OE
);

  fwa_pkg::state_t s;
  fwa_pkg::state_t next_s;
  logic [11:0] cond;
  logic [11:0] rise;
  logic [11:0] base_status;
  logic [32:0] rd;
  logic [31:0] wd;
  logic clr;
  logic ara_win;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // register view: bit 32 flags a mapped address
  function automatic logic [32:0] reg_read(input fwa_pkg::state_t st,
                                          input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      `OFS_CONTROL: begin
        r[`CTL_ON_BIT] = st.op_on;
        r[`CTL_RANGE_BIT] = st.v_range;
      end
      `OFS_STATUS: r[11:0] = st.status;
      `OFS_ALERT1: begin
        r[11:0] = st.en1;
        r[`ALERT_INV_BIT] = st.inv1;
      end
      `OFS_ALERT2: begin
        r[11:0] = st.en2;
        r[`ALERT_INV_BIT] = st.inv2;
      end
      `OFS_VIN_LIM: r[31:0] = {4'h0, st.vin_uv, 4'h0, st.vin_ov};
      `OFS_VOUT_LIM: r[31:0] = {4'h0, st.vout_uv, 4'h0, st.vout_ov};
      `OFS_IOUT_LIM: begin
        r[31:0] = {4'h0, st.iout_w2, 4'h0, st.iout_oc};
        r[`W2_UNDER_BIT] = st.w2_under;
      end
      // R03 raw codes
      `OFS_IOUT_CODE: r[11:0] = st.iout_code;
      `OFS_V_CODE: r[31:0] = {4'h0, st.vout_code, 4'h0, st.vin_code};
      `OFS_LIVE: r[3:0] = {st.tripped, st.op_on & ~st.tripped, st.alert};
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // byte-lane merge of a write into the current value
  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
    return m;
  endfunction

  // whole next state; order: syncs, bus slave, response link, status
  always_comb begin
    next_s = s;
    clr = 1'b0;
    ara_win = 1'b0;
    cond = 12'h000;
    rd = 33'h0_0000_0000;
    wd = 32'h0000_0000;
    // two-stage synchronisers, first stage feeds only the second
    next_s.pin_s1 = {FET_HEALTH_BAD_IN, REGULATION_ACTIVE_IN,
                     OC_TIMEOUT_IN, OV_FAULT_IN, UV_FAULT_IN};
    next_s.pin_s2 = s.pin_s1;
    next_s.scl_s1 = SCL_IN;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_q = s.scl_s2;
    next_s.sda_s1 = SDA_IN;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_q = s.sda_s2;

    // address and data are taken independently and held
    if (S_AXI_AWVALID && !s.aw_full) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s.w_full) begin
      next_s.w_full = 1'b1;
      next_s.w_data = S_AXI_WDATA;
      next_s.w_strb = S_AXI_WSTRB;
    end
    next_s.bvalid = s.bvalid && !S_AXI_BREADY;
    if (s.aw_full && s.w_full && !s.bvalid) begin
      rd = reg_read(s, s.aw_addr);
      wd = wmerge(rd[31:0], s.w_data, s.w_strb);
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
      case (s.aw_addr)
        `OFS_CONTROL: begin
          // R07 clear command or off-then-on
          clr = (wd[`CTL_CLEAR_BIT] && s.w_strb[0]) ||
                (wd[`CTL_ON_BIT] && !s.op_on);
          next_s.op_on = wd[`CTL_ON_BIT];
          next_s.v_range = wd[`CTL_RANGE_BIT];
        end
        `OFS_ALERT1: begin
          next_s.en1 = wd[11:0];
          next_s.inv1 = wd[`ALERT_INV_BIT];
        end
        `OFS_ALERT2: begin
          next_s.en2 = wd[11:0];
          next_s.inv2 = wd[`ALERT_INV_BIT];
        end
        `OFS_VIN_LIM: begin
          next_s.vin_ov = wd[11:0];
          next_s.vin_uv = wd[27:16];
        end
        `OFS_VOUT_LIM: begin
          next_s.vout_ov = wd[11:0];
          next_s.vout_uv = wd[27:16];
        end
        `OFS_IOUT_LIM: begin
          next_s.iout_oc = wd[11:0];
          next_s.iout_w2 = wd[27:16];
          next_s.w2_under = wd[`W2_UNDER_BIT];
        end
        default: ;
      endcase
    end
    next_s.rvalid = s.rvalid && !S_AXI_RREADY;
    if (S_AXI_ARVALID && !s.rvalid) begin
      rd = reg_read(s, S_AXI_ARADDR);
      next_s.rvalid = 1'b1;
      next_s.rdata = rd[31:0];
      next_s.rresp = rd[32] ? `RESP_OKAY : `RESP_SLVERR;
    end

    // alert response slave: only the 0x0C read is answered here
    case (s.ara)
      fwa_pkg::ARA_ADDR: begin
        if (scl_rise) begin
          next_s.shreg = {s.shreg[6:0], s.sda_s2};
          next_s.bitcnt = s.bitcnt + 4'h1;
        end else if (scl_fall && s.bitcnt == 4'h8) begin
          // R16 acknowledge only while alerting
          if (s.shreg == `ARA_READ_BYTE && |s.alert) begin
            next_s.ara = fwa_pkg::ARA_ACK;
            next_s.sda_oe = 1'b1;
          end else begin
            next_s.ara = fwa_pkg::ARA_WAIT;
          end
        end
      end
      fwa_pkg::ARA_ACK: begin
        if (scl_fall) begin
          next_s.ara = fwa_pkg::ARA_SEND;
          next_s.shreg = {DEV_ADDR, 1'b1};
          next_s.sda_oe = ~DEV_ADDR[6];
          next_s.bitcnt = 4'h0;
        end
      end
      fwa_pkg::ARA_SEND: begin
        if (scl_rise) begin
          // R17 a released one seen low loses arbitration
          if (s.shreg[7] && !s.sda_s2) begin
            next_s.ara = fwa_pkg::ARA_WAIT;
            next_s.sda_oe = 1'b0;
          end
          next_s.bitcnt = s.bitcnt + 4'h1;
        end else if (scl_fall) begin
          if (s.bitcnt == 4'h8) begin
            // R18 release at the start of the acknowledge bit
            ara_win = 1'b1;
            next_s.sda_oe = 1'b0;
            next_s.ara = fwa_pkg::ARA_WAIT;
          end else begin
            next_s.shreg = {s.shreg[6:0], 1'b1};
            next_s.sda_oe = ~s.shreg[6];
          end
        end
      end
      default: ;
    endcase
    // start and stop override any byte in progress
    if (bus_start) begin
      next_s.ara = fwa_pkg::ARA_ADDR;
      next_s.bitcnt = 4'h0;
      next_s.sda_oe = 1'b0;
    end else if (bus_stop) begin
      next_s.ara = fwa_pkg::ARA_IDLE;
      next_s.sda_oe = 1'b0;
    end

    // R04 R05 faults come straight from pins, no mask anywhere
    cond[`ST_UV_FAULT] = s.pin_s2[0];
    cond[`ST_OV_FAULT] = s.pin_s2[1];
    cond[`ST_OC_TIMEOUT] = s.pin_s2[2];
    cond[`ST_COMM_ERR] = COMM_ERROR_EVENT;
    cond[`ST_REG_ACTIVE] = s.pin_s2[3];
    cond[`ST_FET_BAD] = s.pin_s2[4];
    if (ADC_VALID) begin
      // R03 codes kept as sampled; R01 R02 scaling is left to software
      next_s.iout_code = ADC_IOUT_CODE;
      // R21 strict comparisons; monitor warnings are per sample
      cond[`ST_IOUT_OC] = ADC_IOUT_CODE > s.iout_oc;
      cond[`ST_IOUT_W2] = s.w2_under ? (ADC_IOUT_CODE < s.iout_w2)
                                     : (ADC_IOUT_CODE > s.iout_w2);
      if (ADC_V_IS_VOUT) begin
        next_s.vout_code = ADC_V_CODE;
        cond[`ST_VOUT_UV] = ADC_V_CODE < s.vout_uv;
        cond[`ST_VOUT_OV] = ADC_V_CODE > s.vout_ov;
      end else begin
        next_s.vin_code = ADC_V_CODE;
        cond[`ST_VIN_UV] = ADC_V_CODE < s.vin_uv;
        cond[`ST_VIN_OV] = ADC_V_CODE > s.vin_ov;
      end
    end

    // R06 R07 latch; a clear keeps any bit whose cause is present in the clear cycle
    base_status = clr ? 12'h000 : s.status;
    next_s.status = base_status | cond;
    // R22 alert response does not touch status
    // R12 R15 only fresh 0 to 1 transitions make an alert
    rise = cond & ~s.status;
    // R11 R13 R14 independent set, common clear, set beats clear
    next_s.alert[0] = ((clr || ara_win) ? 1'b0 : s.alert[0]) |
                      (|(rise & s.en1));
    next_s.alert[1] = ((clr || ara_win) ? 1'b0 : s.alert[1]) |
                      (|(rise & s.en2));
    // R04 any fault trips the output; R08 warnings never reach it
    next_s.tripped = (s.tripped && !(clr && next_s.op_on)) ||
                     (|cond[`ST_OC_TIMEOUT:`ST_UV_FAULT]);
  end

  // edge and frame detection on synchronised bus lines
  assign scl_rise = s.scl_s2 && !s.scl_q;
  assign scl_fall = !s.scl_s2 && s.scl_q;
  assign bus_start = s.scl_s2 && s.scl_q && s.sda_q && !s.sda_s2;
  assign bus_stop = s.scl_s2 && s.scl_q && !s.sda_q && s.sda_s2;

  // single state register; limits except the second current limit start at the disabling extremes
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      next_s_reset();
    end else begin
      s <= next_s;
    end
  end

  // reset image kept in one place for readability
  task automatic next_s_reset();
    s <= '0;
    s.op_on <= 1'b1;
    {s.vin_ov, s.vout_ov, s.iout_oc} <= {3{`RST_OV_LIMIT}};
    {s.vin_uv, s.vout_uv} <= {2{`RST_UV_LIMIT}};
    s.iout_w2 <= `RST_W2_LIMIT;
    // R09 nothing on the first alert, pins released
    s.en1 <= `RST_ALERT1_EN;
    // R10 health-bad on the second alert
    s.en2 <= `RST_ALERT2_EN;
    s.ara <= fwa_pkg::ARA_IDLE;
    // bus lines idle high, so no false edge follows reset
    {s.scl_s1, s.scl_s2, s.scl_q} <= 3'h7;
    {s.sda_s1, s.sda_s2, s.sda_q} <= 3'h7;
  endtask

  // bus slave outputs
  assign S_AXI_AWREADY = !s.aw_full;
  assign S_AXI_WREADY = !s.w_full;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = !s.rvalid;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RDATA = s.rdata;
  assign S_AXI_RRESP = s.rresp;

  // R11 open drain: inverted mode pulls low while inactive
  assign FIRST_ALERT_O = 1'b0;
  assign FIRST_ALERT_OE = s.alert[0] ^ s.inv1;
  assign SECOND_ALERT_O = 1'b0;
  assign SECOND_ALERT_OE = s.alert[1] ^ s.inv2;
  assign SDA_O = 1'b0;
  assign SDA_OE = s.sda_oe;
  assign HOT_SWAP_ON = s.op_on && !s.tripped;

endmodule

// ==== tb/fwa_chk.sv ====
// assertions on the alert block ports
// assumes a bind onto the block top; sees its ports only
module fwa_chk (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // register bus
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic S_AXI_BVALID,
  // condition inputs
  input wire logic UV_FAULT_IN,
  input wire logic OV_FAULT_IN,
  input wire logic OC_TIMEOUT_IN,
  input wire logic REGULATION_ACTIVE_IN,
  input wire logic FET_HEALTH_BAD_IN,
  input wire logic COMM_ERROR_EVENT,
  input wire logic ADC_VALID,
  // outputs watched
  input wire logic HOT_SWAP_ON,
  input wire logic FIRST_ALERT_OE,
  input wire logic SECOND_ALERT_OE,
  input wire logic SDA_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ev_age;
  logic [3:0] flt_age;
  logic cfg_wr;
  logic flt;
  assign flt = UV_FAULT_IN | OV_FAULT_IN | OC_TIMEOUT_IN;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  // cycles since a cause; saturating so stale causes excuse nothing
  always_ff @(posedge MCLK) begin
    if (SRST || ADC_VALID || COMM_ERROR_EVENT ||
        $changed({flt, REGULATION_ACTIVE_IN, FET_HEALTH_BAD_IN}))
      ev_age <= 4'h0;
    else if (ev_age != 4'hF)
      ev_age <= ev_age + 4'h1;
    if (SRST || flt)
      flt_age <= 4'h0;
    else if (flt_age != 4'hF)
      flt_age <= flt_age + 4'h1;
    cfg_wr <= !SRST && (cfg_wr || S_AXI_BVALID);
  end
  reset_idle_a: assert property (
    $fell(SRST) |-> !FIRST_ALERT_OE && !SECOND_ALERT_OE)
    else $error("alert pin driven after reset");
  quiet_cfg_a: assert property (
    !cfg_wr |-> !FIRST_ALERT_OE)
    else $error("first alert before any enable");
  drop_together_a: assert property (
    $fell(FIRST_ALERT_OE) || $fell(SECOND_ALERT_OE)
      |-> !FIRST_ALERT_OE && !SECOND_ALERT_OE)
    else $error("alert pins released apart");
  alert_cause_a: assert property (
    $rose(FIRST_ALERT_OE) || $rose(SECOND_ALERT_OE) |-> ev_age <= 4'h6)
    else $error("alert raised with no new event");
  fault_off_a: assert property (
    $rose(flt) |-> ##[1:6] !HOT_SWAP_ON)
    else $error("fault left the output on");
  warn_keeps_a: assert property (
    $fell(HOT_SWAP_ON)
      |-> flt_age <= 4'h6 || S_AXI_BVALID || $past(S_AXI_BVALID))
    else $error("output dropped with no fault");
  ara_answer_a: assert property (
    $rose(SDA_OE) |-> FIRST_ALERT_OE || SECOND_ALERT_OE)
    else $error("bus answer with no alert");
  rd_latency_a: assert property (
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  rd_done_a: assert property (
    S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
    else $error("read answer not withdrawn");
  // main scenarios reached
  cover property ($rose(FIRST_ALERT_OE));
  cover property ($rose(SDA_OE));
  cover property ($fell(HOT_SWAP_ON));
endmodule

// ==== tb/smbus_host_model.sv ====
// bus host model: alert response reads on the smbus lines
// assumes an open-drain data line with pull-up, resolved by the bench
module smbus_host_model (
  // clock line, high and still outside frames
  output logic scl,
  // data line: pull low, and the resolved level
  output logic sda_oe,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'h1;
    sda_oe = 1'h0;
  end
  // one 800 ns bit: change mid-low, sample mid-high
  task automatic bit_io(input logic b, output logic got);
    scl = 1'h0;
    #200 sda_oe = !b;
    #200 scl = 1'h1;
    #200 got = sda;
    #200;
  endtask
  // receive byte from the alert response address
  task automatic ara(output logic [7:0] d, output logic ack);
    logic g;
    logic [7:0] a;
    a = {7'h0C, 1'h1};
    sda_oe = 1'h1;
    #400;
    for (int i = 7; i >= 0; i--) bit_io(a[i], g);
    bit_io(1'h1, g);
    ack = !g;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    // no acknowledge from the host, then stop
    bit_io(1'h1, g);
    scl = 1'h0;
    #200 sda_oe = 1'h1;
    #200 scl = 1'h1;
    #200 sda_oe = 1'h0;
    // bus free time, so a repeated read shows a real stop and start
    #400;
  endtask
endmodule

// ==== tb/fault_warning_alert_logic_test.sv ====
// self-checking bench for the fault, warning and alert block
// assumes the block, checker and host model are compiled first
`include "fwa_defines.svh"
module fault_warning_alert_logic_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] DEV = 7'h10;
  logic MCLK, SRST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_RREADY, COMM_ERROR_EVENT, ADC_VALID;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rdat;
  logic [11:0] ADC_IOUT_CODE, ADC_V_CODE;
  logic [4:0] pins;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP, resp;
  logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, HOT_SWAP_ON, FIRST_ALERT_OE, SECOND_ALERT_OE;
  logic SCL_IN, SDA_IN, SDA_OE, host_oe;
  logic UV_FAULT_IN, OV_FAULT_IN, OC_TIMEOUT_IN, REGULATION_ACTIVE_IN;
  logic FET_HEALTH_BAD_IN, ADC_V_IS_VOUT;
  int err_total, checks_done;
  assign {FET_HEALTH_BAD_IN, REGULATION_ACTIVE_IN, OC_TIMEOUT_IN,
    OV_FAULT_IN, UV_FAULT_IN} = pins;
  // open-drain data line with pull-up
  assign SDA_IN = !(SDA_OE | host_oe);
  fault_warning_alert_logic #(.DEV_ADDR(DEV))
    fault_warning_alert_logic_i (
    .MCLK, .SRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB(4'hF), .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .UV_FAULT_IN, .OV_FAULT_IN,
    .OC_TIMEOUT_IN, .REGULATION_ACTIVE_IN, .FET_HEALTH_BAD_IN,
    .COMM_ERROR_EVENT, .ADC_VALID, .ADC_IOUT_CODE, .ADC_V_CODE,
    .ADC_V_IS_VOUT, .HOT_SWAP_ON, .FIRST_ALERT_O(),
    .FIRST_ALERT_OE, .SECOND_ALERT_O(), .SECOND_ALERT_OE, .SCL_IN,
    .SDA_IN, .SDA_O(), .SDA_OE);
  smbus_host_model smbus_host_model_i (.scl(SCL_IN), .sda_oe(host_oe),
    .sda(SDA_IN));
  initial begin
    MCLK = 1'h0;
    forever #50 MCLK = ~MCLK;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
    input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  // a wait that ran out counts as a mismatch
  task automatic hang();
    err_total++;
    test_done();
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge MCLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID) begin
        resp = S_AXI_BRESP;
        S_AXI_BREADY <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge MCLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    for (int n = 0; n < 40; n++) begin
      @(posedge MCLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID) begin
        rdat = S_AXI_RDATA;
        resp = S_AXI_RRESP;
        S_AXI_RREADY <= 1'h0;
        return;
      end
    end
    hang();
  endtask
  task automatic rc(input string s, input logic [7:0] a,
    input logic [31:0] e);
    rd(a);
    chk(s, e, rdat);
  endtask
  // one converter sample, then time for status and alert to land
  task automatic adc(input logic [11:0] i, input logic [11:0] v);
    @(posedge MCLK);
    ADC_VALID <= 1'h1;
    ADC_IOUT_CODE <= i;
    ADC_V_CODE <= v;
    @(posedge MCLK);
    ADC_VALID <= 1'h0;
    repeat (3) @(posedge MCLK);
  endtask
  // pins pass a two-stage sync, so allow a few cycles
  task automatic pin(input int k, input logic b);
    @(posedge MCLK);
    pins[k] <= b;
    repeat (6) @(posedge MCLK);
  endtask
  task automatic t_reset();
    @(negedge MCLK);
    chk("alert1 oe", 32'h0, FIRST_ALERT_OE);
    chk("alert2 oe", 32'h0, SECOND_ALERT_OE);
    chk("hot swap", 32'h1, HOT_SWAP_ON);
    rc("alert1 cfg", `OFS_ALERT1, 32'h0);
    rc("alert2 cfg", `OFS_ALERT2, 32'h800);
    rc("status", `OFS_STATUS, 32'h0);
    // second current limit set to under-current so it stays quiet
    wr(`OFS_IOUT_LIM, 32'h80000FFF);
  endtask
  task automatic t_warn();
    wr(`OFS_VIN_LIM, 32'h100);
    wr(`OFS_ALERT1, 32'h100);
    adc(12'h7FF, 12'h100);
    rc("equal vin", `OFS_STATUS, 32'h0);
    adc(12'h7FF, 12'h101);
    rc("vin ov", `OFS_STATUS, 32'h100);
    chk("alert1 oe", 32'h1, FIRST_ALERT_OE);
    chk("alert2 oe", 32'h0, SECOND_ALERT_OE);
    chk("hot swap", 32'h1, HOT_SWAP_ON);
    rc("iout code", `OFS_IOUT_CODE, 32'h7FF);
    rc("vin code", `OFS_V_CODE, 32'h101);
    wr(`OFS_CONTROL, 32'h81);
    rc("cleared", `OFS_STATUS, 32'h0);
    chk("cleared oe", 32'h0, FIRST_ALERT_OE);
    adc(12'h7FF, 12'h101);
    chk("next sample", 32'h1, FIRST_ALERT_OE);
  endtask
  task automatic t_ara();
    logic [7:0] b;
    logic ack;
    for (int n = 0; n < 3 && FIRST_ALERT_OE; n++)
      smbus_host_model_i.ara(b, ack);
    chk("ack", 32'h1, ack);
    chk("address", {25'h0, DEV}, {25'h0, b[7:1]});
    chk("released", 32'h0, FIRST_ALERT_OE);
    rc("status kept", `OFS_STATUS, 32'h100);
  endtask
  task automatic t_fault();
    wr(`OFS_CONTROL, 32'h81);
    wr(`OFS_ALERT1, 32'h7);
    for (int k = 0; k < 3; k++) begin
      pin(k, 1'h1);
      chk("output off", 32'h0, HOT_SWAP_ON);
      chk("fault alert", 32'h1, FIRST_ALERT_OE);
      wr(`OFS_CONTROL, 32'h81);
      rc("persistent", `OFS_STATUS, 32'h1 << k);
      chk("quiet", 32'h0, FIRST_ALERT_OE);
      pin(k, 1'h0);
      wr(`OFS_CONTROL, 32'h0);
      wr(`OFS_CONTROL, 32'h80);
      rc("off then on", `OFS_STATUS, 32'h0);
      chk("output on", 32'h1, HOT_SWAP_ON);
    end
  endtask
  task automatic t_warn2();
    wr(`OFS_ALERT1, 32'h10);
    pin(4, 1'h1);
    chk("alert2 oe", 32'h1, SECOND_ALERT_OE);
    chk("alert1 idle", 32'h0, FIRST_ALERT_OE);
    pin(3, 1'h1);
    @(posedge MCLK);
    COMM_ERROR_EVENT <= 1'h1;
    @(posedge MCLK);
    COMM_ERROR_EVENT <= 1'h0;
    rc("warnings", `OFS_STATUS, 32'h818);
    chk("alert1 oe", 32'h1, FIRST_ALERT_OE);
    chk("hot swap", 32'h1, HOT_SWAP_ON);
    pin(3, 1'h0);
    wr(`OFS_CONTROL, 32'h81);
    rc("after clear", `OFS_STATUS, 32'h800);
    chk("alert1 off", 32'h0, FIRST_ALERT_OE);
    chk("alert2 off", 32'h0, SECOND_ALERT_OE);
    pin(4, 1'h0);
  endtask
  // output voltage limits, with the converter switched to vout
  task automatic t_vout();
    wr(`OFS_CONTROL, 32'h81);
    wr(`OFS_VOUT_LIM, 32'h02000300);
    ADC_V_IS_VOUT <= 1'h1;
    adc(12'h7FF, 12'h200);
    rc("equal vout", `OFS_STATUS, 32'h0);
    adc(12'h7FF, 12'h1FF);
    adc(12'h7FF, 12'h301);
    rc("vout warn", `OFS_STATUS, 32'h600);
    rc("vout code", `OFS_V_CODE, 32'h03010101);
    chk("hot swap", 32'h1, HOT_SWAP_ON);
  endtask
  task automatic t_bad();
    rc("unmapped", 8'h30, 32'h0);
    chk("rd resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    wr(8'h30, 32'hFFFFFFFF);
    chk("wr resp", {30'h0, `RESP_SLVERR}, {30'h0, resp});
  endtask
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID} = 4'h0;
    {S_AXI_RREADY, COMM_ERROR_EVENT, ADC_VALID, ADC_V_IS_VOUT} = 4'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
    {ADC_IOUT_CODE, ADC_V_CODE, pins} = 29'h0;
    SRST = 1'h1;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(posedge MCLK);
    SRST <= 1'h0;
    t_reset();
    t_warn();
    t_ara();
    t_fault();
    t_warn2();
    t_vout();
    t_bad();
    test_done();
  end
endmodule
bind fault_warning_alert_logic fwa_chk fwa_chk_i (.MCLK, .SRST,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY,
  .S_AXI_BVALID, .UV_FAULT_IN, .OV_FAULT_IN, .OC_TIMEOUT_IN,
  .REGULATION_ACTIVE_IN, .FET_HEALTH_BAD_IN, .COMM_ERROR_EVENT,
  .ADC_VALID, .HOT_SWAP_ON, .FIRST_ALERT_OE, .SECOND_ALERT_OE, .SDA_OE);
